// ---- rtl/lcd_timing_params.svh ----
// panel timing constants
`ifndef LCD_TIMING_PARAMS_SVH
`define LCD_TIMING_PARAMS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define LCD_OFS_CTRL    8'h00
`define LCD_OFS_DIV     8'h04
`define LCD_OFS_HTIM    8'h08
`define LCD_OFS_VTIM    8'h0C
`define LCD_OFS_SIZE    8'h10
`define LCD_OFS_GATE    8'h14
`define LCD_OFS_STATUS  8'h18
`define LCD_OFS_DATA    8'h1C

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define LCD_CTRL_EN      0
`define LCD_CTRL_MODE_LO 1
`define LCD_CTRL_MODE_HI 2
`define LCD_CTRL_BW_LO   3
`define LCD_CTRL_BW_HI   4
`define LCD_CTRL_POL_FS  5
`define LCD_CTRL_POL_LS  6
`define LCD_CTRL_POL_OE  7
`define LCD_CTRL_POL_SC  8
`define LCD_CTRL_POL_PD  9
`define LCD_CTRL_GT_LO   10
`define LCD_CTRL_GT_HI   11

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define LCD_CTRL_RST  32'h0000_0000
`define LCD_DIV_RST   32'h0000_0002
`define LCD_HTIM_RST  32'h0000_0000
`define LCD_VTIM_RST  32'h0000_0001
`define LCD_SIZE_RST  32'h0001_0001
`define LCD_GATE_RST  32'h0000_0000
`define LCD_DATA_RST  32'h0000_0000

// ----------------------------------------------------------------
// horizontal interval offsets, in ticks
// ----------------------------------------------------------------
`define LCD_SYNC_ADD      13'h0001
`define LCD_FRONT_TFT_ADD 13'h0003
`define LCD_FRONT_GT_ADD  13'h0004
`define LCD_FRONT_NT_ADD  13'h0002
`define LCD_BACK_ADD      13'h0001
`define LCD_MIN_SH_PERIOD 9'h003

`define AXI_OKAY   2'b00
`define AXI_SLVERR 2'b10

`endif

// ---- rtl/lcd_timing_pkg.sv ----
// types of the panel timing generator
package lcd_timing_pkg;

   typedef enum logic [1:0] {
      H_SYNC   = 2'b00,
      H_FRONT  = 2'b01,
      H_ACTIVE = 2'b11,
      H_BACK   = 2'b10
   } h_state_t;

   typedef enum logic [1:0] {
      V_SYNC   = 2'b00,
      V_FRONT  = 2'b01,
      V_ACTIVE = 2'b11,
      V_BACK   = 2'b10
   } v_state_t;

   typedef enum logic [1:0] {
      MODE_TFT  = 2'b00,
      MODE_GATE = 2'b01,
      MODE_CSTN = 2'b10,
      MODE_MONO = 2'b11
   } panel_mode_t;

endpackage

// ---- rtl/lcd_panel_timing_generator.sv ----
// panel timing generator with AXI4-Lite registers
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "lcd_timing_params.svh"

module lcd_panel_timing_generator
   import lcd_timing_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   output var  logic [1:0]  s_axi_bresp,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output var  logic        line_sync,
   output var  logic        frame_sync,
   output var  logic        output_enable,
   output var  logic        shift_clock,
   output var  logic [17:0] pixel_data_lines,
   output var  logic        line_start_pulse,
   output var  logic        gate_clock_pulse,
   output var  logic        gate_power_pulse,
   output var  logic        alternation
);

   // ----------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------
   logic [31:0] ctrl_reg, div_reg, htim_reg, vtim_reg, size_reg, gate_reg, data_reg;
   logic [7:0]  aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;
   logic        aw_have_reg, w_have_reg;
   logic [31:0] status_word;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   wire logic do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
   wire logic wr_ok    = (aw_addr_reg[7:5] == 3'b000) && (aw_addr_reg[4:2] != 3'd6) && (aw_addr_reg[1:0] == 2'b00);

   // aw and w in either order; answer once both held
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         aw_have_reg   <= 1'b0;
         w_have_reg    <= 1'b0;
         aw_addr_reg   <= 8'h00;
         w_data_reg    <= 32'h0000_0000;
         w_strb_reg    <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `AXI_OKAY;
      end else begin
         s_axi_awready <= !aw_have_reg && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready  <= !w_have_reg && !(s_axi_wvalid && s_axi_wready);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? `AXI_OKAY : `AXI_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            aw_have_reg   <= 1'b0;
            w_have_reg    <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_reg <= `LCD_CTRL_RST;
         div_reg  <= `LCD_DIV_RST;
         htim_reg <= `LCD_HTIM_RST;
         vtim_reg <= `LCD_VTIM_RST;
         size_reg <= `LCD_SIZE_RST;
         gate_reg <= `LCD_GATE_RST;
         data_reg <= `LCD_DATA_RST;
      end else if (do_write) begin
         unique case (aw_addr_reg)
            `LCD_OFS_CTRL: ctrl_reg <= merge(ctrl_reg, w_data_reg, w_strb_reg) & 32'h0000_0FFF;
            `LCD_OFS_DIV:  div_reg  <= merge(div_reg, w_data_reg, w_strb_reg) & 32'h0000_00FF;
            `LCD_OFS_HTIM: htim_reg <= merge(htim_reg, w_data_reg, w_strb_reg) & 32'h00FF_FFFF;
            `LCD_OFS_VTIM: vtim_reg <= merge(vtim_reg, w_data_reg, w_strb_reg) & 32'h00FF_FFFF;
            `LCD_OFS_SIZE: size_reg <= merge(size_reg, w_data_reg, w_strb_reg) & 32'h0FFF_0FFF;
            `LCD_OFS_GATE: gate_reg <= merge(gate_reg, w_data_reg, w_strb_reg);
            `LCD_OFS_DATA: data_reg <= merge(data_reg, w_data_reg, w_strb_reg) & 32'h0003_FFFF;
            default: ;
         endcase
      end
   end

   // read answered one cycle after address
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `AXI_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `AXI_OKAY;
            unique case (s_axi_araddr)
               `LCD_OFS_CTRL:   s_axi_rdata <= ctrl_reg;
               `LCD_OFS_DIV:    s_axi_rdata <= div_reg;
               `LCD_OFS_HTIM:   s_axi_rdata <= htim_reg;
               `LCD_OFS_VTIM:   s_axi_rdata <= vtim_reg;
               `LCD_OFS_SIZE:   s_axi_rdata <= size_reg;
               `LCD_OFS_GATE:   s_axi_rdata <= gate_reg;
               `LCD_OFS_STATUS: s_axi_rdata <= status_word;
               `LCD_OFS_DATA:   s_axi_rdata <= data_reg;
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= `AXI_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // field decode
   // ----------------------------------------------------------------
   panel_mode_t mode;
   logic        en, tft, pol_fs, pol_ls, pol_oe, pol_sc, pol_pd;
   logic [1:0]  bw_code, gate_sel;
   logic [7:0]  pixel_clock_divisor, hw, hf, hb, vw, vf, vb, gd, gw, pd, ad;
   logic [11:0] line_pixel_count, ymax;

   always_comb begin
      en       = ctrl_reg[`LCD_CTRL_EN];
      mode     = panel_mode_t'(ctrl_reg[`LCD_CTRL_MODE_HI:`LCD_CTRL_MODE_LO]);
      bw_code  = ctrl_reg[`LCD_CTRL_BW_HI:`LCD_CTRL_BW_LO];
      pol_fs   = ctrl_reg[`LCD_CTRL_POL_FS];
      pol_ls   = ctrl_reg[`LCD_CTRL_POL_LS];
      pol_oe   = ctrl_reg[`LCD_CTRL_POL_OE];
      pol_sc   = ctrl_reg[`LCD_CTRL_POL_SC];
      pol_pd   = ctrl_reg[`LCD_CTRL_POL_PD];
      gate_sel = ctrl_reg[`LCD_CTRL_GT_HI:`LCD_CTRL_GT_LO];
      tft      = (mode == MODE_TFT) || (mode == MODE_GATE);
      pixel_clock_divisor      = div_reg[7:0];
      hw       = htim_reg[7:0];
      hf       = htim_reg[15:8];
      hb       = htim_reg[23:16];
      vw       = vtim_reg[7:0];
      vf       = vtim_reg[15:8];
      vb       = vtim_reg[23:16];
      line_pixel_count     = (size_reg[11:0] == 12'h000) ? 12'h001 : size_reg[11:0];
      ymax     = (size_reg[27:16] == 12'h000) ? 12'h001 : size_reg[27:16];
      gd       = gate_reg[7:0];
      gw       = gate_reg[15:8];
      pd       = gate_reg[23:16];
      ad       = gate_reg[31:24];
   end

   // ----------------------------------------------------------------
   // pixel and shift clock enables
   // ----------------------------------------------------------------
   h_state_t    h_state_reg;
   v_state_t    v_state_reg;
   logic [7:0]  pix_cnt_reg;
   logic [2:0]  sh_cnt_reg;
   logic [12:0] h_cnt_reg;
   logic [11:0] v_cnt_reg;
   logic        pix_tick, shift_tick, h_tick, h_last, line_end, act_entry;
   logic [2:0]  bw_last, bw_half;
   logic [12:0] h_len;

   always_comb begin
      unique case (bw_code)
         2'd0: begin bw_last = 3'd0; bw_half = 3'd0; end
         2'd1: begin bw_last = 3'd1; bw_half = 3'd1; end
         2'd2: begin bw_last = 3'd3; bw_half = 3'd2; end
         2'd3: begin bw_last = 3'd7; bw_half = 3'd4; end
      endcase
   end

   assign pix_tick   = en && (pix_cnt_reg == pixel_clock_divisor);
   assign shift_tick = pix_tick && ((mode != MODE_MONO) || (sh_cnt_reg == bw_last));

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         pix_cnt_reg <= 8'h00;
      end else if (!en || pix_tick) begin
         pix_cnt_reg <= 8'h00;
      end else begin
         pix_cnt_reg <= pix_cnt_reg + 8'h01;
      end
   end

   // phase reload puts first shift bus/2 pixels in
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         sh_cnt_reg <= 3'd0;
      end else if (act_entry) begin
         sh_cnt_reg <= bw_half;
      end else if (pix_tick) begin
         sh_cnt_reg <= (sh_cnt_reg >= bw_last) ? 3'd0 : sh_cnt_reg + 3'd1;
      end
   end

   // ----------------------------------------------------------------
   // horizontal timing
   // ----------------------------------------------------------------
   always_comb begin
      unique case (h_state_reg)
         H_SYNC:   h_len = {5'h00, hw} + `LCD_SYNC_ADD;
         H_FRONT: begin
            if (mode == MODE_GATE) begin
               h_len = {5'h00, hf} + `LCD_FRONT_GT_ADD;
            end else if (tft) begin
               h_len = {5'h00, hf} + `LCD_FRONT_TFT_ADD;
            end else begin
               h_len = {5'h00, hf} + `LCD_FRONT_NT_ADD;
            end
         end
         H_ACTIVE: h_len = {1'b0, line_pixel_count};
         H_BACK:   h_len = {5'h00, hb} + `LCD_BACK_ADD;
      endcase
   end

   // non-TFT blanking in pixel clocks
   assign h_tick    = (!tft && (h_state_reg != H_ACTIVE)) ? pix_tick : shift_tick;
   assign h_last    = h_tick && (h_cnt_reg == h_len - 13'h0001);
   assign line_end  = h_last && (h_state_reg == H_BACK);
   assign act_entry = h_last && (h_state_reg == H_FRONT);

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         h_state_reg <= H_SYNC;
         h_cnt_reg   <= 13'h0000;
      end else if (!en) begin
         h_state_reg <= H_SYNC;
         h_cnt_reg   <= 13'h0000;
      end else if (h_last) begin
         h_cnt_reg <= 13'h0000;
         unique case (h_state_reg)
            H_SYNC:   h_state_reg <= H_FRONT;
            H_FRONT:  h_state_reg <= H_ACTIVE;
            H_ACTIVE: h_state_reg <= H_BACK;
            H_BACK:   h_state_reg <= H_SYNC;
         endcase
      end else if (h_tick) begin
         h_cnt_reg <= h_cnt_reg + 13'h0001;
      end
   end

   // ----------------------------------------------------------------
   // vertical timing, counted in whole lines
   // ----------------------------------------------------------------
   function automatic logic [11:0] v_len(input v_state_t s, input logic [7:0] w, input logic [7:0] f,
                                         input logic [7:0] b, input logic [11:0] y);
      unique case (s)
         V_SYNC:   v_len = (w == 8'h00) ? 12'h001 : {4'h0, w};
         V_FRONT:  v_len = {4'h0, f};
         V_ACTIVE: v_len = y;
         V_BACK:   v_len = {4'h0, b};
      endcase
   endfunction

   function automatic v_state_t v_succ(input v_state_t s);
      unique case (s)
         V_SYNC:   v_succ = V_FRONT;
         V_FRONT:  v_succ = V_ACTIVE;
         V_ACTIVE: v_succ = V_BACK;
         V_BACK:   v_succ = V_SYNC;
      endcase
   endfunction

   v_state_t v_next;

   // zero-line waits skipped
   always_comb begin
      v_next = v_succ(v_state_reg);
      for (int i = 0; i < 2; i++) begin
         if (v_len(v_next, vw, vf, vb, ymax) == 12'h000) begin
            v_next = v_succ(v_next);
         end
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         v_state_reg <= V_SYNC;
         v_cnt_reg   <= 12'h000;
      end else if (!en) begin
         v_state_reg <= V_SYNC;
         v_cnt_reg   <= 12'h000;
      end else if (line_end) begin
         if (v_cnt_reg >= v_len(v_state_reg, vw, vf, vb, ymax) - 12'h001) begin
            v_state_reg <= v_next;
            v_cnt_reg   <= 12'h000;
         end else begin
            v_cnt_reg <= v_cnt_reg + 12'h001;
         end
      end
   end

   // ----------------------------------------------------------------
   // gate TFT sideband, from last data of line
   // ----------------------------------------------------------------
   logic [9:0] post_reg;
   logic [9:0] g_rise, g_fall, p_rise;
   logic       gate_mode, oe_raw, fs_raw, sc_run, alt_reg;

   assign gate_mode = (mode == MODE_GATE);
   assign oe_raw    = (h_state_reg == H_ACTIVE) && (v_state_reg == V_ACTIVE);
   assign fs_raw    = (v_state_reg == V_SYNC) && (tft || (h_state_reg != H_SYNC));
   assign g_rise    = {2'b00, gd} + 10'h001;
   assign g_fall    = g_rise + {2'b00, gw} + 10'h001;
   assign p_rise    = g_fall + {2'b00, pd};

   // saturates: no repeat before next data line
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         post_reg <= 10'h3FF;
      end else if (!en) begin
         post_reg <= 10'h3FF;
      end else if (h_last && oe_raw) begin
         post_reg <= 10'h000;
      end else if (shift_tick && (post_reg != 10'h3FF)) begin
         post_reg <= post_reg + 10'h001;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         alt_reg <= 1'b0;
      end else if (gate_mode && shift_tick && (post_reg == {2'b00, ad})) begin
         alt_reg <= !alt_reg;
      end
   end

   // ----------------------------------------------------------------
   // output stage, all registered, polarity applied last to sync, enable, shift clock and data only
   // ----------------------------------------------------------------
   always_comb begin
      unique case (gate_sel)
         2'd1:    sc_run = !fs_raw;
         2'd2:    sc_run = oe_raw;
         default: sc_run = 1'b1;
      endcase
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         line_sync        <= 1'b0;
         frame_sync       <= 1'b0;
         output_enable    <= 1'b0;
         shift_clock      <= 1'b0;
         pixel_data_lines <= 18'h0_0000;
      end else begin
         line_sync        <= pol_ls ^ (en && h_state_reg == H_SYNC);
         frame_sync       <= pol_fs ^ (en && fs_raw);
         output_enable    <= pol_oe ^ (en && oe_raw);
         shift_clock      <= pol_sc ^ (shift_tick && sc_run);
         pixel_data_lines <= {18{pol_pd}} ^ ((en && oe_raw) ? data_reg[17:0] : 18'h0_0000);
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         line_start_pulse <= 1'b0;
         gate_clock_pulse <= 1'b0;
         gate_power_pulse <= 1'b1;
         alternation      <= 1'b0;
      end else begin
         line_start_pulse <= gate_mode && (v_state_reg == V_ACTIVE) && (h_state_reg == H_FRONT)
                             && (h_cnt_reg == h_len - 13'h0001);
         gate_clock_pulse <= gate_mode && (post_reg >= g_rise) && (post_reg < g_fall);
         gate_power_pulse <= !(gate_mode && (post_reg >= g_rise) && (post_reg < p_rise));
         alternation      <= gate_mode && alt_reg;
      end
   end

   // ----------------------------------------------------------------
   // status: position and shift rate check
   // ----------------------------------------------------------------
   logic [8:0] sh_period;
   logic       rate_bad;

   assign sh_period   = {1'b0, pixel_clock_divisor} + 9'h001;
   assign rate_bad    = (mode != MODE_MONO) && (sh_period < `LCD_MIN_SH_PERIOD);
   assign status_word = {14'h0000, fs_raw, rate_bad, 2'b00, v_state_reg, v_cnt_reg};

endmodule // lcd_panel_timing_generator
`default_nettype wire

// ---- verification/lcd_panel_monitor.sv ----
// concurrent checks on the panel timing generator ports
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_monitor (
   input wire logic        mclk,
   input wire logic        sys_rst,
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        line_sync,
   input wire logic        frame_sync,
   input wire logic        output_enable,
   input wire logic        shift_clock,
   input wire logic [17:0] pixel_data_lines,
   input wire logic        line_start_pulse,
   input wire logic        gate_clock_pulse,
   input wire logic        gate_power_pulse
);
   logic [31:0] ctrl_reg;
   logic [7:0]  div_reg;
   logic [5:0]  settle_reg;
   logic [5:0]  gap_reg;
   logic        take, run, tft, nm, ls_a, oe_a, sc_a;
   // snoop needs aw and w in one beat
   assign take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   assign run  = settle_reg == 6'h3f;
   assign tft  = run && ctrl_reg[0] && ctrl_reg[2:1] == 2'b00;
   assign nm   = run && ctrl_reg[0] && ctrl_reg[2:1] != 2'b11 && ctrl_reg[11:10] == 2'b00;
   assign ls_a = line_sync ^ ctrl_reg[6];
   assign oe_a = output_enable ^ ctrl_reg[7];
   assign sc_a = shift_clock ^ ctrl_reg[8];
   // checks wait for a new setting to settle
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_reg   <= 32'h0000_0000;
         div_reg    <= 8'h02;
         settle_reg <= 6'h3f;
      end else if (take) begin
         settle_reg <= 6'h00;
         if (s_axi_awaddr == 8'h00) ctrl_reg <= s_axi_wdata;
         if (s_axi_awaddr == 8'h04) div_reg <= s_axi_wdata[7:0];
      end else if (!run) begin
         settle_reg <= settle_reg + 6'h01;
      end
   end
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) gap_reg <= 6'h00;
      else gap_reg <= sc_a ? 6'h00 : gap_reg + 6'(gap_reg != 6'h3f);
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   a_reset_idle: assert property (run && ctrl_reg[9:0] == 10'h000 |->
      !line_sync && !frame_sync && !output_enable && !shift_clock && gate_power_pulse) else $error("idle levels");
   a_sync_blank: assert property (tft && ls_a |-> !oe_a) else $error("sync with enable");
   a_front_gap: assert property (tft && $fell(ls_a) |-> !oe_a [*3]) else $error("front gap");
   a_back_gap: assert property (tft && $fell(oe_a) |-> !ls_a) else $error("back gap");
   a_pixel_rate: assert property (nm && sc_a |-> gap_reg == div_reg[5:0]) else $error("shift rate");
   a_clock_stop: assert property (tft && ctrl_reg[11:10] == 2'b10 && !oe_a && !$past(oe_a) |->
      !sc_a) else $error("shift clock not stopped");
   a_data_idle: assert property (tft && !oe_a && !$past(oe_a) |->
      pixel_data_lines == {18{ctrl_reg[9]}}) else $error("idle data level");
   a_power_edge: assert property ($rose(gate_clock_pulse) |-> $fell(gate_power_pulse)) else $error("power edge");
   a_power_low: assert property (gate_clock_pulse |-> !gate_power_pulse) else $error("power high");
   a_start_width: assert property ($rose(line_start_pulse) |=> !line_start_pulse) else $error("start width");
endmodule // lcd_panel_monitor
bind lcd_panel_timing_generator lcd_panel_monitor mon_u (.*);
`default_nettype wire

// ---- verification/lcd_panel_model.sv ----
// passive panel: pulse lengths in mclk
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_model (
   input  wire logic        mclk,
   input  wire logic        inv,
   input  wire logic        line_sync,
   input  wire logic        output_enable,
   input  wire logic        gate_clock_pulse,
   input  wire logic [17:0] pixel_data_lines,
   input  wire logic        alternation,
   output var  logic        alt_flip,
   output var  logic [7:0]  sync_len,
   output var  logic [7:0]  oe_len,
   output var  logic [7:0]  period,
   output var  logic [7:0]  gate_len,
   output var  logic [17:0] pix
);
   logic [7:0] c_ls = 8'h00, c_oe = 8'h00, c_per = 8'h00, c_gt = 8'h00;
   logic       ls_q = 1'b0, oe_q = 1'b0, gt_q = 1'b0, alt_q = 1'b0, ls_a, oe_a;
   assign ls_a = line_sync ^ inv;
   assign oe_a = output_enable ^ inv;
   always_ff @(posedge mclk) begin
      ls_q <= ls_a;
      oe_q <= oe_a;
      gt_q <= gate_clock_pulse;
      c_ls <= ls_a ? c_ls + 8'h01 : 8'h00;
      c_oe <= oe_a ? c_oe + 8'h01 : 8'h00;
      c_gt <= gate_clock_pulse ? c_gt + 8'h01 : 8'h00;
      c_per <= (ls_a && !ls_q) ? 8'h01 : c_per + 8'h01;
      if (ls_a && !ls_q) period <= c_per;
      if (!ls_a && ls_q) sync_len <= c_ls;
      if (!oe_a && oe_q) oe_len <= c_oe;
      if (!gate_clock_pulse && gt_q) gate_len <= c_gt;
      if (oe_a) pix <= pixel_data_lines;
      if (oe_a && !oe_q) alt_q <= alternation;
      if (oe_a && !oe_q) alt_flip <= alternation != alt_q;
   end
endmodule // lcd_panel_model
`default_nettype wire

// ---- verification/tb_lcd_panel_timing_generator.sv ----
// self-checking bench of the panel timing generator
`timescale 1ns/1ps
`default_nettype none
`include "lcd_timing_params.svh"
module tb_lcd_panel_timing_generator
   import lcd_timing_pkg::*;
;
   logic        mclk = 1'b0, sys_rst = 1'b1, inv = 1'b0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        line_sync, frame_sync, output_enable, shift_clock;
   logic        line_start_pulse, gate_clock_pulse, gate_power_pulse, alternation, alt_flip;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [17:0] pixel_data_lines, pix;
   logic [7:0]  sync_len, oe_len, period, gate_len;
   int          n_errors = 0, samples_checked = 0;
   localparam logic [7:0]  ofs [7] = '{`LCD_OFS_CTRL, `LCD_OFS_DIV, `LCD_OFS_HTIM, `LCD_OFS_VTIM,
                                       `LCD_OFS_SIZE, `LCD_OFS_GATE, `LCD_OFS_DATA};
   localparam logic [31:0] rsv [7] = '{`LCD_CTRL_RST, `LCD_DIV_RST, `LCD_HTIM_RST, `LCD_VTIM_RST,
                                       `LCD_SIZE_RST, `LCD_GATE_RST, `LCD_DATA_RST};
   lcd_panel_timing_generator dut_u (.*);
   lcd_panel_model pm_u (.mclk, .inv, .line_sync, .output_enable, .gate_clock_pulse, .pixel_data_lines,
      .alternation, .alt_flip, .sync_len, .oe_len, .period, .gate_len, .pix);
   task automatic complete_run;
      if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic guard(input int n);
      if (n >= 40) begin
         n_errors++;
         complete_run();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge mclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      guard(n);
      chk({30'h0, s_axi_bresp}, {30'h0, r});
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge mclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      guard(n);
      chk(s_axi_rdata, d);
      chk({30'h0, s_axi_rresp}, {30'h0, r});
   endtask
   // hw=1 hf=2 hb=1 line_pixel_count=4, lengths in mclk
   task automatic run(input logic [31:0] dv, ct, input logic iv, input logic [31:0] p, s, o, px);
      wr(`LCD_OFS_DIV, dv, `AXI_OKAY);
      wr(`LCD_OFS_CTRL, ct, `AXI_OKAY);
      inv <= iv;
      repeat (300) @(posedge mclk);
      chk({24'h0, period}, p);
      chk({24'h0, sync_len}, s);
      chk({24'h0, oe_len}, o);
      chk({14'h0, pix}, px);
   endtask
   initial begin
      forever #2.5 mclk = ~mclk;
   end
   initial begin
      repeat (20) @(posedge mclk);
      sys_rst <= 1'b0;
      foreach (ofs[i]) rd(ofs[i], rsv[i], `AXI_OKAY);
      rd(8'h20, 32'h0000_0000, `AXI_SLVERR);
      wr(`LCD_OFS_STATUS, 32'h0000_0001, `AXI_SLVERR);
      wr(`LCD_OFS_HTIM, 32'h0001_0201, `AXI_OKAY);
      wr(`LCD_OFS_VTIM, 32'h0001_0101, `AXI_OKAY);
      wr(`LCD_OFS_SIZE, 32'h0002_0004, `AXI_OKAY);
      wr(`LCD_OFS_DATA, 32'h0002_aaaa, `AXI_OKAY);
      rd(`LCD_OFS_HTIM, 32'h0001_0201, `AXI_OKAY);
      run(32'h0000_0000, 32'h0000_0001, 1'b0, 32'd13, 32'd2, 32'd4, 32'h0002_aaaa);
      run(32'h0000_0000, 32'h0000_0be1, 1'b1, 32'd13, 32'd2, 32'd4, 32'h0001_5555);
      run(32'h0000_0002, 32'h0000_0001, 1'b0, 32'd39, 32'd6, 32'd12, 32'h0002_aaaa);
      wr(`LCD_OFS_GATE, 32'h0201_0102, `AXI_OKAY);
      run(32'h0000_0000, 32'h0000_0003, 1'b0, 32'd14, 32'd2, 32'd4, 32'h0002_aaaa);
      chk({24'h0, gate_len}, 32'd2);
      chk({31'h0, alt_flip}, 32'd1);
      wr(`LCD_OFS_CTRL, 32'h0000_0017, `AXI_OKAY);
      repeat (200) @(posedge mclk);
      sys_rst <= 1'b1;
      repeat (3) @(posedge mclk);
      chk({28'h0, gate_power_pulse, line_sync, frame_sync, output_enable}, 32'h0000_0008);
      sys_rst <= 1'b0;
      repeat (100) @(posedge mclk);
      complete_run();
   end
endmodule // tb_lcd_panel_timing_generator
`default_nettype wire
